//--- verilog/tdmck_cfg.svh
// Constants for the TDM timing block: offsets, fields, resets, rates.
// Assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus.
`ifndef TDMCK_CFG_SVH
`define TDMCK_CFG_SVH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TDMCK_SYS_CLK_KHZ      50000
`define TDMCK_FRAME_RATE_HZ    8000
`define TDMCK_REF_TIMEOUT_US   250
`define TDMCK_CHANNELS         256
`define TDMCK_F4M_KHZ          4096
`define TDMCK_F8M_KHZ          8192
`define TDMCK_F16M_KHZ         16384
`define TDMCK_F32M_KHZ         32768
`define TDMCK_F1544K_KHZ       1544
`define TDMCK_F2048K_KHZ       2048
`define TDMCK_F19M_KHZ         19440
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TDMCK_ADDR_CTRL        8'h00
`define TDMCK_ADDR_RSW         8'h04
`define TDMCK_ADDR_OFF0        8'h08
`define TDMCK_ADDR_OFF1        8'h0c
`define TDMCK_ADDR_OFF2        8'h10
`define TDMCK_ADDR_STATUS      8'h14
`define TDMCK_ADDR_MASK        8'h18
`define TDMCK_ADDR_REFST       8'h1c
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define TDMCK_CTRL_CK4_BIT     6
`define TDMCK_CTRL_SLVPLL_BIT  13
`define TDMCK_CTRL_WMASK       16'h207f
`define TDMCK_CTRL_RST         16'h0002
`define TDMCK_RSW_FORCE_BIT    2
`define TDMCK_RSW_RST          3'h0
`define TDMCK_OFF_19M_BIT      10
`define TDMCK_OFF_RST          11'h000
`endif

//--- verilog/tdmck_pkg.sv
// Types shared by the TDM timing block.
// Assumes tdmck_cfg.svh is included by the users of the constants.
package tdmck_pkg;
  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TDMCK_DIV_SLAVE,
    TDMCK_MUL_SLAVE,
    TDMCK_MASTER
  } tdmck_mode_e;
  // ----------------------------------------------------------------
  // Captured AHB address phase
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } tdmck_aph_s;
endpackage : tdmck_pkg

//--- verilog/tdmck_timing.sv
// TDM clock, frame pulse and reference monitor block with AHB-Lite regs.
// Assumes one 50 MHz clock; pins are asynchronous and are synchronised.
//
// Overview of operation
// - Oscillator select picks internal or line timing
// - Each reference accepted independently, any rate
// - Reference switch register chooses preferred reference
// - Slave mode ignores references unless enabled
// - Master mode flags each failed reference high
// - Slave mode holds failure flags low unless PLL enabled
// - Three fixed frame pulses match clocks
// - Fourth frame pulse follows programmable clock
// - Divided slave pulses not narrower than input
// - Offset pulses delayed by programmed channels
// - Select bit turns third offset into 19M pulse
// - 19M pulse needs master or PLL enable
// - Four fixed clock outputs driven
// - Two programmable clock outputs
// - Divided slave clocks not above line clock
// - Telecom and 19M clocks need PLL availability
`timescale 1ns/1ps
`include "tdmck_cfg.svh"
module tdmck_timing
  import tdmck_pkg::*;
#(
  parameter int FRAME_CYCLES = `TDMCK_SYS_CLK_KHZ * 1000 / `TDMCK_FRAME_RATE_HZ,
  parameter int REF_TIMEOUT  = `TDMCK_REF_TIMEOUT_US * `TDMCK_SYS_CLK_KHZ / 1000
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  output logic             irq,
  input  wire logic        ext_oscillator_select,
  input  wire logic [3:0]  timing_ref_in,
  input  wire logic        frame_sync_in,
  output logic      [3:0]  ref_loss_flag,
  output logic      [3:0]  frame_sync_out,
  output logic      [1:0]  shifted_frame_sync,
  output logic             shifted_frame_sync_two,
  output logic      [5:0]  clock_out_bank
);
  // ----------------------------------------------------------------
  // Derived constants
  // ----------------------------------------------------------------
  localparam int FW          = $clog2(FRAME_CYCLES + 1);
  localparam int TW          = $clog2(REF_TIMEOUT + 1);
  localparam int CHAN_CYCLES = FRAME_CYCLES / `TDMCK_CHANNELS;

  function automatic logic [31:0] nco_inc(input int khz);
    logic [63:0] t;
    t = 64'(khz) << 32;
    return 32'(t / 64'(`TDMCK_SYS_CLK_KHZ));
  endfunction : nco_inc

  function automatic logic [FW-1:0] per_cyc(input int khz);
    return FW'((`TDMCK_SYS_CLK_KHZ + khz - 1) / khz);
  endfunction : per_cyc

  localparam logic [31:0] INC4M  = nco_inc(`TDMCK_F4M_KHZ);
  localparam logic [31:0] INC8M  = nco_inc(`TDMCK_F8M_KHZ);
  localparam logic [31:0] INC16M = nco_inc(`TDMCK_F16M_KHZ);
  localparam logic [31:0] INC32M = nco_inc(`TDMCK_F32M_KHZ);
  localparam logic [31:0] INC1M5 = nco_inc(`TDMCK_F1544K_KHZ);
  localparam logic [31:0] INC2M  = nco_inc(`TDMCK_F2048K_KHZ);
  localparam logic [31:0] INC19M = nco_inc(`TDMCK_F19M_KHZ);
  localparam logic [FW-1:0] W4M  = per_cyc(`TDMCK_F4M_KHZ);
  localparam logic [FW-1:0] W8M  = per_cyc(`TDMCK_F8M_KHZ);
  localparam logic [FW-1:0] W16M = per_cyc(`TDMCK_F16M_KHZ);
  localparam logic [FW-1:0] W32M = per_cyc(`TDMCK_F32M_KHZ);
  localparam logic [FW-1:0] W19M = per_cyc(`TDMCK_F19M_KHZ);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] osc_sync_reg;
  logic [3:0] ref_s1_reg;
  logic [3:0] ref_s2_reg;
  logic [3:0] ref_s3_reg;
  logic [2:0] fs_sync_reg;
  logic       osc_sel;
  logic       fs_rise;
  logic       fs_fall;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      osc_sync_reg <= 2'h0;
      ref_s1_reg   <= 4'h0;
      ref_s2_reg   <= 4'h0;
      ref_s3_reg   <= 4'h0;
      fs_sync_reg  <= 3'h0;
    end else begin
      osc_sync_reg <= {osc_sync_reg[0], ext_oscillator_select};
      ref_s1_reg   <= timing_ref_in;
      ref_s2_reg   <= ref_s1_reg;
      ref_s3_reg   <= ref_s2_reg;
      fs_sync_reg  <= {fs_sync_reg[1:0], frame_sync_in};
    end
  end

  assign osc_sel = osc_sync_reg[1];
  assign fs_rise = fs_sync_reg[1] & ~fs_sync_reg[2];
  assign fs_fall = ~fs_sync_reg[1] & fs_sync_reg[2];

  // ----------------------------------------------------------------
  // Registers and AHB-Lite slave
  // ----------------------------------------------------------------
  tdmck_aph_s  aph_reg;
  logic        rd_pend_reg;
  logic [31:0] hrdata_reg;
  logic [15:0] ctrl_reg;
  logic [2:0]  rsw_reg;
  logic [10:0] off_reg [0:2];
  logic [3:0]  status_reg;
  logic [3:0]  mask_reg;
  logic [3:0]  ref_fail;
  logic [3:0]  ref_fail_d_reg;
  logic [1:0]  sel_ref;
  logic [31:0] rd_mux;
  logic        take;
  logic        wr_en;
  logic        st_clr;
  tdmck_mode_e mode;
  logic        pll_avail;

  assign take      = hsel & hready & htrans[1];
  assign wr_en     = aph_reg.valid & aph_reg.write & hready;
  assign st_clr    = rd_pend_reg & (aph_reg.addr == `TDMCK_ADDR_STATUS);
  assign hreadyout = ~rd_pend_reg;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      aph_reg     <= '0;
      rd_pend_reg <= 1'b0;
    end else if (hready) begin
      aph_reg     <= '{addr: haddr[7:0], write: hwrite, valid: take};
      rd_pend_reg <= take & ~hwrite;
    end else begin
      rd_pend_reg <= 1'b0;
    end
  end

  always_comb begin
    unique case (aph_reg.addr)
      `TDMCK_ADDR_CTRL:   rd_mux = {16'h0000, ctrl_reg};
      `TDMCK_ADDR_RSW:    rd_mux = {29'h0000_0000, rsw_reg};
      `TDMCK_ADDR_OFF0:   rd_mux = {21'h00_0000, off_reg[0]};
      `TDMCK_ADDR_OFF1:   rd_mux = {21'h00_0000, off_reg[1]};
      `TDMCK_ADDR_OFF2:   rd_mux = {21'h00_0000, off_reg[2]};
      `TDMCK_ADDR_STATUS: rd_mux = {28'h000_0000, status_reg};
      `TDMCK_ADDR_MASK:   rd_mux = {28'h000_0000, mask_reg};
      `TDMCK_ADDR_REFST:  rd_mux = {22'h00_0000, pll_avail, osc_sel, 2'h0,
                                    sel_ref, ref_fail};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl_reg  <= `TDMCK_CTRL_RST;
      rsw_reg   <= `TDMCK_RSW_RST;
      mask_reg  <= 4'h0;
      for (int k = 0; k < 3; k++) begin
        off_reg[k] <= `TDMCK_OFF_RST;
      end
    end else if (wr_en) begin
      unique case (aph_reg.addr)
        `TDMCK_ADDR_CTRL: ctrl_reg   <= hwdata[15:0] & `TDMCK_CTRL_WMASK;
        `TDMCK_ADDR_RSW:  rsw_reg    <= hwdata[2:0];
        `TDMCK_ADDR_OFF0: off_reg[0] <= hwdata[10:0] & 11'h0ff;
        `TDMCK_ADDR_OFF1: off_reg[1] <= hwdata[10:0] & 11'h0ff;
        `TDMCK_ADDR_OFF2: off_reg[2] <= hwdata[10:0] & 11'h4ff;
        `TDMCK_ADDR_MASK: mask_reg   <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky failure events; a new event wins over the read clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_reg     <= 4'h0;
      ref_fail_d_reg <= 4'h0;
    end else begin
      ref_fail_d_reg <= ref_fail;
      status_reg     <= (status_reg & ~{4{st_clr}}) | (ref_fail & ~ref_fail_d_reg);
    end
  end

  assign irq = |(status_reg & mask_reg);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (ctrl_reg[1:0])
      2'h0:    mode = TDMCK_DIV_SLAVE;
      2'h1:    mode = TDMCK_MUL_SLAVE;
      default: mode = TDMCK_MASTER;
    endcase
  end

  assign pll_avail = (mode == TDMCK_MASTER) | ctrl_reg[`TDMCK_CTRL_SLVPLL_BIT];

  // ----------------------------------------------------------------
  // Reference monitors
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_ref
    logic [TW-1:0] wd_reg;
    logic          fail_reg;
    always_ff @(posedge sys_clk) begin
      if (!rstn || !pll_avail) begin
        wd_reg   <= '0;
        fail_reg <= 1'b0;
      end else if (ref_s2_reg[i] ^ ref_s3_reg[i]) begin
        wd_reg   <= '0;
        fail_reg <= 1'b0;
      end else if (wd_reg == TW'(REF_TIMEOUT)) begin
        fail_reg <= 1'b1;
      end else begin
        wd_reg   <= wd_reg + 1'b1;
      end
    end
    assign ref_fail[i] = fail_reg;
  end

  assign ref_loss_flag = ref_fail;

  always_comb begin
    sel_ref = rsw_reg[1:0];
    if (!rsw_reg[`TDMCK_RSW_FORCE_BIT] && ref_fail[rsw_reg[1:0]]) begin
      for (int i = 3; i >= 0; i--) begin
        if (!ref_fail[i]) begin
          sel_ref = 2'(i);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame timing
  // ----------------------------------------------------------------
  logic [FW-1:0] frame_pos_reg;
  logic [FW-1:0] fs_cnt_reg;
  logic [FW-1:0] in_w_reg;
  logic          frame_start;

  // Internal timing or input frame alignment
  assign frame_start = (frame_pos_reg == FW'(FRAME_CYCLES - 1)) | (~osc_sel & fs_rise);

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      frame_pos_reg <= '0;
    end else if (frame_start) begin
      frame_pos_reg <= '0;
    end else begin
      frame_pos_reg <= frame_pos_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fs_cnt_reg <= '0;
      in_w_reg   <= '0;
    end else begin
      if (!fs_sync_reg[1]) begin
        fs_cnt_reg <= '0;
      end else if (fs_cnt_reg != '1) begin
        fs_cnt_reg <= fs_cnt_reg + 1'b1;
      end
      if (fs_fall) begin
        in_w_reg <= fs_cnt_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock outputs
  // ----------------------------------------------------------------
  logic [31:0] inc [0:5];
  logic [1:0]  rate_idx [0:3];
  logic [5:0]  ck_en;
  logic [5:0]  ck_reg;
  logic [1:0]  ck3_sel;
  logic [1:0]  line_rate;

  assign ck3_sel   = ctrl_reg[5:4];
  // Line rate as set by software
  assign line_rate = ctrl_reg[3:2];

  always_comb begin
    inc[0] = INC4M;
    inc[1] = INC8M;
    inc[2] = INC16M;
    unique case (ck3_sel)
      2'h0:    inc[3] = INC4M;
      2'h1:    inc[3] = INC8M;
      2'h2:    inc[3] = INC16M;
      default: inc[3] = INC32M;
    endcase
    inc[4] = ctrl_reg[`TDMCK_CTRL_CK4_BIT] ? INC2M : INC1M5;
    inc[5] = INC19M;
  end

  assign rate_idx[0] = 2'h0;
  assign rate_idx[1] = 2'h1;
  assign rate_idx[2] = 2'h2;
  assign rate_idx[3] = ck3_sel;

  for (genvar i = 0; i < 6; i++) begin : g_ck
    logic [31:0] acc_reg;
    logic        ck_q_reg;
    if (i < 4) begin : g_low
      assign ck_en[i] = !(mode == TDMCK_DIV_SLAVE && rate_idx[i] > line_rate);
    end else begin : g_pll
      assign ck_en[i] = pll_avail;
    end
    always_ff @(posedge sys_clk) begin
      if (!rstn || frame_start) begin
        acc_reg <= 32'h0000_0000;
      end else begin
        acc_reg <= acc_reg + inc[i];
      end
    end
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        ck_q_reg <= 1'b0;
      end else begin
        ck_q_reg <= acc_reg[31] & ck_en[i];
      end
    end
    assign ck_reg[i] = ck_q_reg;
  end

  assign clock_out_bank = ck_reg;

  // ----------------------------------------------------------------
  // Frame pulse outputs
  // ----------------------------------------------------------------
  logic [FW-1:0] nom_w [0:3];
  logic [FW-1:0] fp_w  [0:3];
  logic [3:0]    fso_reg;
  logic [1:0]    sh_reg;
  logic          sh2_reg;
  logic [2:0]    sh_hit;
  int            off_start [0:2];

  always_comb begin
    nom_w[0] = W4M;
    nom_w[1] = W8M;
    nom_w[2] = W16M;
    unique case (ck3_sel)
      2'h0:    nom_w[3] = W4M;
      2'h1:    nom_w[3] = W8M;
      2'h2:    nom_w[3] = W16M;
      default: nom_w[3] = W32M;
    endcase
  end

  for (genvar i = 0; i < 4; i++) begin : g_fp
    logic fp_q_reg;
    assign fp_w[i] = (mode == TDMCK_DIV_SLAVE && in_w_reg > nom_w[i]) ?
                     in_w_reg : nom_w[i];
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        fp_q_reg <= 1'b0;
      end else begin
        fp_q_reg <= frame_pos_reg < fp_w[i];
      end
    end
    assign fso_reg[i] = fp_q_reg;
  end

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      off_start[k] = int'(off_reg[k][7:0]) * CHAN_CYCLES;
      sh_hit[k]    = int'(frame_pos_reg) >= off_start[k] &&
                     int'(frame_pos_reg) < off_start[k] + int'(W4M);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sh_reg  <= 2'h0;
      sh2_reg <= 1'b0;
    end else begin
      sh_reg <= sh_hit[1:0];
      // 19M pulse when selected and available
      if (off_reg[2][`TDMCK_OFF_19M_BIT]) begin
        sh2_reg <= pll_avail & (frame_pos_reg < W19M);
      end else begin
        sh2_reg <= sh_hit[2];
      end
    end
  end

  assign frame_sync_out         = fso_reg;
  assign shifted_frame_sync     = sh_reg;
  assign shifted_frame_sync_two = sh2_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  flag_low_a:
  assert property (!pll_avail |=> ref_loss_flag == 4'h0)
    else $error("failure flag set while references ignored");
  flag_set_a:
  assert property (g_ref[2].wd_reg == TW'(REF_TIMEOUT) && pll_avail &&
                   !(ref_s2_reg[2] ^ ref_s3_reg[2]) |=> ref_loss_flag[2])
    else $error("reference timeout did not raise flag");
  ref_ign_a:
  assert property (!pll_avail |=> g_ref[1].wd_reg == '0)
    else $error("reference watched while ignored");
  ref_force_a:
  assert property (rsw_reg[`TDMCK_RSW_FORCE_BIT] |-> sel_ref == rsw_reg[1:0])
    else $error("forced reference not selected");
  ck_div_a:
  assert property (mode == TDMCK_DIV_SLAVE && ck3_sel > line_rate
                   |=> !clock_out_bank[3])
    else $error("clock above line rate in divided slave");
  ck_pll_a:
  assert property (!pll_avail |=> clock_out_bank[5:4] == 2'h0)
    else $error("unavailable clock toggling");
  sync19_gate_a:
  assert property (off_reg[2][`TDMCK_OFF_19M_BIT] && !pll_avail
                   |=> !shifted_frame_sync_two)
    else $error("19M pulse while unavailable");
  sync19_on_a:
  assert property (off_reg[2][`TDMCK_OFF_19M_BIT] && pll_avail &&
                   frame_pos_reg == '0 |=> shifted_frame_sync_two)
    else $error("19M pulse missing at boundary");
  fp_align_a:
  assert property (frame_start |-> ##2 (frame_sync_out[2] && !clock_out_bank[2]) [*2]
                   ##1 frame_sync_out[2] [*2])
    else $error("frame pulse not aligned with clock");
  fp_width_a:
  assert property (mode == TDMCK_DIV_SLAVE && frame_pos_reg < in_w_reg
                   |=> frame_sync_out == 4'hf)
    else $error("frame pulse narrower than input");
  off_start_a:
  assert property (int'(frame_pos_reg) == off_start[0] |=> shifted_frame_sync[0])
    else $error("offset pulse missing");
  osc_free_a:
  assert property (osc_sel && frame_pos_reg == FW'(2) |=> frame_pos_reg == FW'(3))
    else $error("internal frame disturbed");

  ref_fail_c: cover property (pll_avail && $rose(ref_loss_flag[1]));
  sync19_c:   cover property (off_reg[2][`TDMCK_OFF_19M_BIT] && $rose(shifted_frame_sync_two));
  div_fp_c:   cover property (mode == TDMCK_DIV_SLAVE && in_w_reg > W4M && fs_rise);
  irq_c:      cover property ($rose(irq));

endmodule : tdmck_timing

//--- sim/tdmck_ref_model.sv
// Far-side model: oscillator strap, four reference sources, input frame pulse.
// Assumes the bench steps ref_en, osc_sel and fp_w just after a clock edge.
`timescale 1ns/1ps
module tdmck_ref_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] ref_en,
  input  wire logic       osc_sel,
  input  wire logic [7:0] fp_w,
  output logic            ext_oscillator_select,
  output logic      [3:0] timing_ref_in,
  output logic            frame_sync_in
);
  int         cnt   = 0;
  logic [3:0] ref_q = 4'h0;
  logic       fs_q  = 1'b0;
  assign ext_oscillator_select = osc_sel;
  assign timing_ref_in         = ref_q;
  assign frame_sync_in         = fs_q;
  always @(posedge sys_clk) begin
    cnt <= cnt + 1;
    for (int i = 0; i < 4; i++) begin
      if (ref_en[i] && cnt % (3 + 2 * i) == 0) begin
        ref_q[i] <= ~ref_q[i];
      end
    end
    fs_q <= (cnt % 512) < int'(fp_w);
  end
endmodule : tdmck_ref_model

//--- sim/testbench.sv
// Self-checking bench for the TDM timing block: bus, references, pulses.
// Assumes short frame and watchdog counts and the reference model.
`timescale 1ns/1ps
`include "tdmck_cfg.svh"
module testbench;
  import tdmck_pkg::*;
  localparam int FC = 512;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  ref_en = 4'hf;
  logic        osc_sel = 1'b1;
  logic [7:0]  fp_w = 8'h02;
  logic        hreadyout, hresp, irq, ext_oscillator_select, frame_sync_in;
  logic        shifted_frame_sync_two;
  logic [31:0] hrdata, rd, k;
  logic [3:0]  timing_ref_in, ref_loss_flag, frame_sync_out;
  logic [1:0]  shifted_frame_sync;
  logic [5:0]  clock_out_bank;
  logic [6:0]  pulses;
  int          errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  assign pulses = {shifted_frame_sync_two, shifted_frame_sync, frame_sync_out};
  tdmck_timing #(.FRAME_CYCLES(FC), .REF_TIMEOUT(64)) u_dut (
    .sys_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .ext_oscillator_select,
    .timing_ref_in, .frame_sync_in, .ref_loss_flag, .frame_sync_out,
    .shifted_frame_sync, .shifted_frame_sync_two, .clock_out_bank
  );
  tdmck_ref_model u_ref (
    .sys_clk, .ref_en, .osc_sel, .fp_w, .ext_oscillator_select, .timing_ref_in,
    .frame_sync_in
  );
  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  function automatic int nom(input int khz);
    return (50000 + khz - 1) / khz;
  endfunction : nom
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge sys_clk iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk iff hreadyout === 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input string what);
    ahb(1'b0, a, 32'h0);
    cmp(rd, e, what);
    cmp(hresp, 1'b0, "hresp");
  endtask : chk
  task automatic width(input int i, input int e);
    @(posedge sys_clk iff pulses[i] === 1'b0);
    @(posedge sys_clk iff pulses[i] === 1'b1);
    n = 0;
    while (pulses[i] === 1'b1) begin
      n++;
      @(posedge sys_clk);
    end
    cmp(n, e, "pulse width");
  endtask : width
  task automatic hi(input int i, input logic e);
    n = 0;
    repeat (256) begin
      @(posedge sys_clk);
      n += int'(clock_out_bank[i] === 1'b1);
    end
    cmp(n > 40, e, "clock activity");
  endtask : hi
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    void'($urandom(32'h7665963a));
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    chk(`TDMCK_ADDR_CTRL, 32'h2, "ctrl reset");
    chk(`TDMCK_ADDR_RSW, 32'h0, "rsw reset");
    ahb(1'b1, 8'h20, 32'hffffffff);
    chk(8'h20, 32'h0, "unmapped");
    k = $urandom;
    ahb(1'b1, `TDMCK_ADDR_CTRL, k);
    chk(`TDMCK_ADDR_CTRL, k & `TDMCK_CTRL_WMASK, "ctrl rw");
    ahb(1'b1, `TDMCK_ADDR_CTRL, 32'h2);
    chk(`TDMCK_ADDR_REFST, 32'h300, "osc high");
    ahb(1'b1, `TDMCK_ADDR_RSW, 32'h6);
    chk(`TDMCK_ADDR_REFST, 32'h320, "forced ref");
    width(0, nom(`TDMCK_F4M_KHZ));
    width(1, nom(`TDMCK_F8M_KHZ));
    width(2, nom(`TDMCK_F16M_KHZ));
    hi(0, 1'b1);
    hi(5, 1'b1);
    hi(4, 1'b1);
    for (int r = 0; r < 4; r++) begin
      ahb(1'b1, `TDMCK_ADDR_CTRL, 32'h2 | (r << 4));
      width(3, nom(`TDMCK_F4M_KHZ << r));
    end
    for (int j = 0; j < 2; j++) begin
      k = $urandom % 256;
      ahb(1'b1, `TDMCK_ADDR_OFF0 + 8'(4 * j), k);
      @(posedge sys_clk iff pulses[0] === 1'b0);
      @(posedge sys_clk iff pulses[0] === 1'b1);
      n = 0;
      while (pulses[4 + j] !== 1'b1) begin
        n++;
        @(posedge sys_clk);
      end
      cmp(n, k * (FC / 256), "offset gap");
    end
    ahb(1'b1, `TDMCK_ADDR_OFF2, 32'h400);
    width(6, nom(`TDMCK_F19M_KHZ));
    ahb(1'b1, `TDMCK_ADDR_CTRL, 32'h10);
    hi(1, 1'b0);
    hi(3, 1'b0);
    hi(4, 1'b0);
    hi(5, 1'b0);
    cmp(pulses[6], 1'b0, "19m pulse off");
    osc_sel <= 1'b0;
    fp_w <= 8'd20;
    repeat (2 * FC) @(posedge sys_clk);
    width(0, 20);
    chk(`TDMCK_ADDR_REFST, 32'h20, "osc low");
    osc_sel <= 1'b1;
    ref_en <= 4'hd;
    repeat (200) @(posedge sys_clk);
    cmp(ref_loss_flag, 4'h0, "slave flags");
    ahb(1'b1, `TDMCK_ADDR_CTRL, 32'h2000);
    repeat (200) @(posedge sys_clk);
    cmp(ref_loss_flag, 4'h2, "slave pll flag");
    width(6, nom(`TDMCK_F19M_KHZ));
    hi(5, 1'b1);
    ref_en <= 4'hf;
    repeat (30) @(posedge sys_clk);
    cmp(ref_loss_flag, 4'h0, "flag clears");
    ahb(1'b1, `TDMCK_ADDR_CTRL, 32'h2);
    chk(`TDMCK_ADDR_STATUS, 32'h2, "old event");
    ref_en <= 4'hb;
    repeat (200) @(posedge sys_clk);
    cmp(ref_loss_flag, 4'h4, "master flag");
    cmp(irq, 1'b0, "masked irq");
    ahb(1'b1, `TDMCK_ADDR_MASK, 32'h4);
    @(posedge sys_clk);
    cmp(irq, 1'b1, "irq raised");
    chk(`TDMCK_ADDR_STATUS, 32'h4, "status");
    @(posedge sys_clk);
    cmp(irq, 1'b0, "irq cleared");
    chk(`TDMCK_ADDR_STATUS, 32'h0, "status clear");
    final_report();
  end
endmodule : testbench
